// *** src/txc_top.sv ***
`timescale 1ns/1ps
module txc_top #(
	parameter logic [6:0] DEV_ADDR = txc_pkg::DEV_ADDR,
	parameter logic [7:0] CLK_PERIOD_CYC = txc_pkg::CLK_OUT_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// preset select straps: ground, open or supply
	input wire logic [txc_pkg::LVL_W-1:0] preset_select_low,
	input wire logic [txc_pkg::LVL_W-1:0] preset_select_high,
	// data pin: transmit data in preset mode, serial data in host mode
	input wire logic transmit_data_pin_in,
	output logic transmit_data_pin_out,
	output logic transmit_data_pin_oe_n,
	// clock pin: clock out in preset mode, serial clock in host mode
	input wire logic clock_output_pin_in,
	output logic clock_output_pin_out,
	output logic clock_output_pin_oe_n,
	// operating mode seen at the straps
	output logic host_mode,
	output logic [3:0] preset_index,
	output logic strap_fault,
	// modulator controls
	output logic modulation_select_bit,
	output logic [txc_pkg::CAR_W-1:0] tx_carrier_frequency_word_word,
	output logic [2:0] amplifier_level_field,
	output logic gauss_shaping,
	output logic amp_keyed_on,
	output logic tx_data_bit
);
	import txc_pkg::*;

	typedef struct packed {
		logic strap_done;
		logic host;
		logic fault;
		logic [3:0] preset_idx;
		logic [REG_W-1:0] mod_cfg;
		logic [REG_W-1:0] pa_cfg;
		logic [REG_W-1:0] car_a;
		logic [REG_W-1:0] car_b;
		logic [REG_W-1:0] car_c;
		logic [REG_W-1:0] dev_cfg;
		logic fsk;
		logic [CAR_W-1:0] carrier_frequency_word;
		logic [2:0] level;
		logic gauss;
		logic amp_on;
		logic data_bit;
		logic clk_out;
		logic clk_oe_n;
		logic sda_oe_n;
	} txc_top_s;

	localparam txc_top_s ST_RST = '{
		strap_done: 1'b0,
		host: 1'b0,
		fault: 1'b0,
		preset_idx: 4'h0,
		mod_cfg: RST_MOD_CFG,
		pa_cfg: RST_PA_CFG,
		car_a: RST_CAR,
		car_b: RST_CAR,
		car_c: RST_CAR,
		dev_cfg: RST_DEV_CFG,
		fsk: 1'b0,
		carrier_frequency_word: '0,
		level: 3'h0,
		gauss: 1'b0,
		amp_on: 1'b0,
		data_bit: 1'b0,
		clk_out: 1'b0,
		clk_oe_n: 1'b1,
		sda_oe_n: 1'b1
	};

	txc_top_s st_ff;
	txc_top_s nxt_st;

	txc_reg_if rif ();

	logic scl_seen;
	logic sda_seen;
	logic sda_pull;
	logic div_clk;
	logic [CAR_W-1:0] carrier;
	logic [CAR_W-1:0] dev_offset;
	logic [3:0] idx_lo;
	logic [3:0] idx_hi;

	// an undefined pin level counts as supply so the index stays in range
	function automatic logic [3:0] pin_rank(input logic [1:0] lvl);
		logic [3:0] r;
		r = {2'h0, lvl};
		if (r > PIN_LEVELS - 4'h1) begin
			r = PIN_LEVELS - 4'h1;
		end
		return r;
	endfunction

	assign idx_lo = pin_rank(preset_select_low);
	assign idx_hi = pin_rank(preset_select_high);

	// bus lines only reach the bus logic in host mode; idle high otherwise
	assign scl_seen = st_ff.host ? clock_output_pin_in : 1'b1;
	assign sda_seen = st_ff.host ? transmit_data_pin_in : 1'b1;

	txc_i2c_slave #(
		.ADDR(DEV_ADDR)
	) u_bus (
		.clk(clk),
		.rst(rst),
		.scl(scl_seen),
		.sda(sda_seen),
		.sda_pull(sda_pull),
		.rif(rif.ctrl)
	);

	// the preset clock only runs once the straps chose preset mode
	txc_clkdiv #(
		.PERIOD_CYC(CLK_PERIOD_CYC)
	) u_div (
		.clk(clk),
		.rst(rst),
		.en(st_ff.strap_done && !st_ff.host),
		.clk_div(div_clk)
	);

	// read path: unmapped offsets answer with zero
	always_comb begin
		case (rif.raddr)
			OFF_MOD_CFG: rif.rdata = st_ff.mod_cfg;
			OFF_PA_CFG: rif.rdata = st_ff.pa_cfg;
			OFF_CAR_A: rif.rdata = st_ff.car_a;
			OFF_CAR_B: rif.rdata = st_ff.car_b;
			OFF_CAR_C: rif.rdata = st_ff.car_c;
			OFF_DEV_CFG: rif.rdata = st_ff.dev_cfg;
			default: rif.rdata = RST_UNMAPPED;
		endcase
	end

	// carrier word, high byte first; host supplies it already rounded
	assign carrier = {st_ff.car_a, st_ff.car_b, st_ff.car_c};
	// deviation steps are eight carrier steps apart
	assign dev_offset = {{(CAR_W - DEV_W - DEV_SHIFT){1'b0}},
		st_ff.dev_cfg[DEV_MSB:DEV_LSB], {DEV_SHIFT{1'b0}}};

	always_comb begin
		nxt_st = st_ff;

		// straps are caught once, the cycle after reset releases
		if (!st_ff.strap_done) begin
			nxt_st.strap_done = 1'b1;
			nxt_st.host = (preset_select_low == PIN_GND) &&
				(preset_select_high == PIN_GND);
			nxt_st.preset_idx = 4'(idx_hi * PIN_LEVELS + idx_lo);
			// a high data pin at power-up may misconfigure preset parts
			nxt_st.fault = !nxt_st.host && transmit_data_pin_in;
		end

		// register writes only exist in host mode; every register is a byte
		if (rif.wr_en && st_ff.host) begin
			case (rif.waddr)
				OFF_MOD_CFG: nxt_st.mod_cfg = rif.wdata;
				OFF_PA_CFG: nxt_st.pa_cfg = rif.wdata;
				OFF_CAR_A: nxt_st.car_a = rif.wdata;
				OFF_CAR_B: nxt_st.car_b = rif.wdata;
				OFF_CAR_C: nxt_st.car_c = rif.wdata;
				OFF_DEV_CFG: nxt_st.dev_cfg = rif.wdata;
				default: begin
				end
			endcase
		end

		// modulator controls follow the registers
		nxt_st.fsk = st_ff.mod_cfg[MOD_SEL_BIT];
		// level code 0..7 maps power level 1..8, about 2.5 dB per step
		nxt_st.level = st_ff.pa_cfg[LVL_MSB:LVL_LSB];
		nxt_st.gauss = st_ff.dev_cfg[GAUSS_BIT];

		// data only comes from the pin in preset mode
		nxt_st.data_bit = st_ff.strap_done && !st_ff.host && transmit_data_pin_in;

		// fsk steers frequency with data; ask keys the amplifier instead
		if (st_ff.fsk == MOD_FSK) begin
			nxt_st.carrier_frequency_word = st_ff.data_bit ? carrier + dev_offset : carrier;
			nxt_st.amp_on = 1'b1;
		end else begin
			nxt_st.carrier_frequency_word = carrier;
			nxt_st.amp_on = st_ff.data_bit;
		end

		// clock pin: driven in preset mode, released as an input in host mode
		nxt_st.clk_out = div_clk;
		nxt_st.clk_oe_n = !(st_ff.strap_done && !st_ff.host);

		// data pin: open drain, pulled low only for ack and read zeros
		nxt_st.sda_oe_n = !(st_ff.host && sda_pull);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// all outputs but the data pin output, tied low, straight from the state register
	assign transmit_data_pin_out = 1'b0;
	assign transmit_data_pin_oe_n = st_ff.sda_oe_n;
	assign clock_output_pin_out = st_ff.clk_out;
	assign clock_output_pin_oe_n = st_ff.clk_oe_n;
	assign host_mode = st_ff.host;
	assign preset_index = st_ff.preset_idx;
	assign strap_fault = st_ff.fault;
	assign modulation_select_bit = st_ff.fsk;
	assign tx_carrier_frequency_word_word = st_ff.carrier_frequency_word;
	assign amplifier_level_field = st_ff.level;
	assign gauss_shaping = st_ff.gauss;
	assign amp_keyed_on = st_ff.amp_on;
	assign tx_data_bit = st_ff.data_bit;
endmodule // txc_top

// *** pkg/txc_pkg.sv ***
package txc_pkg;

	// register map, 8-bit registers on the two-wire bus
	localparam int REG_W = 8;
	localparam logic [7:0] OFF_MOD_CFG = 8'h00;
	localparam logic [7:0] OFF_PA_CFG = 8'h06;
	localparam logic [7:0] OFF_CAR_A = 8'h0B;
	localparam logic [7:0] OFF_CAR_B = 8'h0C;
	localparam logic [7:0] OFF_CAR_C = 8'h0D;
	localparam logic [7:0] OFF_DEV_CFG = 8'h0E;

	// field positions
	localparam int MOD_SEL_BIT = 0;
	localparam int LVL_MSB = 2;
	localparam int LVL_LSB = 0;
	localparam int DEV_MSB = 6;
	localparam int DEV_LSB = 0;
	localparam int GAUSS_BIT = 7;

	// modulation select encoding
	localparam logic MOD_ASK = 1'b0;
	localparam logic MOD_FSK = 1'b1;

	// reset values
	localparam logic [7:0] RST_MOD_CFG = 8'h00;
	localparam logic [7:0] RST_PA_CFG = 8'h00;
	localparam logic [7:0] RST_CAR = 8'h00;
	localparam logic [7:0] RST_DEV_CFG = 8'h00;
	localparam logic [7:0] RST_UNMAPPED = 8'h00;

	// carrier word is 24 bits; deviation lsb is 8 carrier lsbs (65536 / 8192)
	localparam int CAR_W = 24;
	localparam int DEV_W = 7;
	localparam int DEV_SHIFT = 3;

	// select pin levels: ground, open, supply
	localparam int LVL_W = 2;
	localparam logic [1:0] PIN_GND = 2'h0;
	localparam logic [1:0] PIN_OPEN = 2'h1;
	localparam logic [1:0] PIN_VDD = 2'h2;
	localparam logic [3:0] PIN_LEVELS = 4'h3;
	localparam logic [3:0] PRESET_HOST = 4'h0;

	// two-wire device address, value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2A;

	// preset clock output timing
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int CLK_OUT_HZ = 800_000;
	localparam int CLK_DIV_W = 8;
	localparam int CLK_OUT_PERIOD_INT = SYS_CLK_HZ / CLK_OUT_HZ;
	localparam logic [7:0] CLK_OUT_PERIOD_CYC = 8'(CLK_OUT_PERIOD_INT);

endpackage

// *** pkg/txc_reg_if.sv ***
`timescale 1ns/1ps
interface txc_reg_if;
	logic wr_en;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] raddr;
	logic [7:0] rdata;

	// bus side issues writes and read addresses
	modport ctrl (
		output wr_en,
		output waddr,
		output wdata,
		output raddr,
		input rdata
	);

	// register bank side
	modport bank (
		input wr_en,
		input waddr,
		input wdata,
		input raddr,
		output rdata
	);
endinterface

// *** src/txc_clkdiv.sv ***
`timescale 1ns/1ps
module txc_clkdiv #(
	parameter logic [7:0] PERIOD_CYC = txc_pkg::CLK_OUT_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic en,
	// divided clock
	output logic clk_div
);
	import txc_pkg::*;

	if (PERIOD_CYC < 8'h02) begin : g_chk
		$error("txc_clkdiv: period must be at least two cycles");
	end

	typedef struct packed {
		logic [7:0] cnt;
		logic out;
	} txc_div_s;

	txc_div_s st_ff;
	txc_div_s nxt_st;

	// high for the first half period, low for the rest; odd periods run high one short
	always_comb begin
		nxt_st = st_ff;
		if (!en) begin
			nxt_st.cnt = 8'h00;
			nxt_st.out = 1'b0;
		end else begin
			if (st_ff.cnt == PERIOD_CYC - 8'h01) begin
				nxt_st.cnt = 8'h00;
			end else begin
				nxt_st.cnt = st_ff.cnt + 8'h01;
			end
			nxt_st.out = (nxt_st.cnt < (PERIOD_CYC >> 1));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign clk_div = st_ff.out;
endmodule // txc_clkdiv

// *** src/txc_i2c_slave.sv ***
`timescale 1ns/1ps
module txc_i2c_slave #(
	parameter logic [6:0] ADDR = txc_pkg::DEV_ADDR
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus lines as seen by the device
	input wire logic scl,
	input wire logic sda,
	output logic sda_pull,
	// register access
	txc_reg_if.ctrl rif
);
	import txc_pkg::*;

	if (ADDR[6:3] == 4'h0 || ADDR[6:3] == 4'hF) begin : g_chk
		$error("txc_i2c_slave: address lies in a reserved group");
	end

	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WR, S_ACK, S_RD, S_RACK} txc_i2c_e;

	typedef struct packed {
		txc_i2c_e state;
		logic scl_q;
		logic sda_q;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic first;
		logic rw;
		logic pull;
		logic wr_en;
		logic [7:0] waddr;
		logic [7:0] wdata;
	} txc_i2c_s;

	txc_i2c_s st_ff;
	txc_i2c_s nxt_st;
	logic rise;
	logic fall;
	logic start;
	logic stop;

	// line events from the previous sample of each line
	assign rise = scl & ~st_ff.scl_q;
	assign fall = ~scl & st_ff.scl_q;
	assign start = st_ff.scl_q & scl & st_ff.sda_q & ~sda;
	assign stop = st_ff.scl_q & scl & ~st_ff.sda_q & sda;

	// bits are taken on scl rise, driven after scl fall
	always_comb begin
		nxt_st = st_ff;
		nxt_st.scl_q = scl;
		nxt_st.sda_q = sda;
		nxt_st.wr_en = 1'b0;
		if (start) begin
			nxt_st.state = S_ADDR;
			nxt_st.cnt = 4'h0;
			nxt_st.pull = 1'b0;
			nxt_st.first = 1'b1;
		end else if (stop) begin
			nxt_st.state = S_IDLE;
			nxt_st.pull = 1'b0;
		end else begin
			case (st_ff.state)
				S_IDLE: begin
					nxt_st.pull = 1'b0;
				end
				S_ADDR, S_WR: begin
					if (rise && st_ff.cnt != 4'h8) begin
						nxt_st.sh = {st_ff.sh[6:0], sda};
						nxt_st.cnt = st_ff.cnt + 4'h1;
					end
					if (fall && st_ff.cnt == 4'h8) begin
						if (st_ff.state == S_ADDR) begin
							// a foreign address leaves the bus alone until next start
							if (st_ff.sh[7:1] == ADDR) begin
								nxt_st.pull = 1'b1;
								nxt_st.rw = st_ff.sh[0];
								nxt_st.state = S_ACK;
							end else begin
								nxt_st.state = S_IDLE;
							end
						end else begin
							nxt_st.pull = 1'b1;
							nxt_st.state = S_ACK;
							if (st_ff.first) begin
								nxt_st.ptr = st_ff.sh;
								nxt_st.first = 1'b0;
							end else begin
								nxt_st.wr_en = 1'b1;
								nxt_st.waddr = st_ff.ptr;
								nxt_st.wdata = st_ff.sh;
								nxt_st.ptr = st_ff.ptr + 8'h01;
							end
						end
					end
				end
				S_ACK: begin
					if (fall) begin
						nxt_st.cnt = 4'h0;
						if (st_ff.rw) begin
							nxt_st.sh = rif.rdata;
							nxt_st.pull = ~rif.rdata[7];
							nxt_st.state = S_RD;
						end else begin
							nxt_st.pull = 1'b0;
							nxt_st.state = S_WR;
						end
					end
				end
				S_RD: begin
					if (rise) begin
						nxt_st.cnt = st_ff.cnt + 4'h1;
					end
					if (fall) begin
						if (st_ff.cnt == 4'h8) begin
							nxt_st.pull = 1'b0;
							nxt_st.ptr = st_ff.ptr + 8'h01;
							nxt_st.state = S_RACK;
						end else begin
							nxt_st.sh = {st_ff.sh[6:0], 1'b0};
							nxt_st.pull = ~st_ff.sh[6];
						end
					end
				end
				S_RACK: begin
					// a not-acknowledge ends the read
					if (rise && sda) begin
						nxt_st.state = S_IDLE;
					end else if (fall) begin
						nxt_st.cnt = 4'h0;
						nxt_st.sh = rif.rdata;
						nxt_st.pull = ~rif.rdata[7];
						nxt_st.state = S_RD;
					end
				end
				default: begin
					nxt_st.state = S_IDLE;
					nxt_st.pull = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '{state: S_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sda_pull = st_ff.pull;
	assign rif.wr_en = st_ff.wr_en;
	assign rif.waddr = st_ff.waddr;
	assign rif.wdata = st_ff.wdata;
	assign rif.raddr = st_ff.ptr;
endmodule // txc_i2c_slave

// *** sim/txc_props.sv ***
`timescale 1ns/1ps
module txc_props #(
	parameter logic [7:0] CLK_PERIOD_CYC = txc_pkg::CLK_OUT_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// straps and pins
	input wire logic [txc_pkg::LVL_W-1:0] preset_select_low,
	input wire logic [txc_pkg::LVL_W-1:0] preset_select_high,
	input wire logic transmit_data_pin_in,
	input wire logic transmit_data_pin_out,
	input wire logic transmit_data_pin_oe_n,
	input wire logic clock_output_pin_in,
	input wire logic clock_output_pin_out,
	input wire logic clock_output_pin_oe_n,
	// mode and modulator outputs
	input wire logic host_mode,
	input wire logic [3:0] preset_index,
	input wire logic strap_fault,
	input wire logic modulation_select_bit,
	input wire logic [txc_pkg::CAR_W-1:0] tx_carrier_frequency_word_word,
	input wire logic [2:0] amplifier_level_field,
	input wire logic gauss_shaping,
	input wire logic amp_keyed_on,
	input wire logic tx_data_bit
);
	import txc_pkg::*;
	typedef struct packed {logic [7:0] run; logic arm; logic seen; logic prev;} txc_chk_s;
	txc_chk_s st_ff, nxt_st;
	// phase length of the clock pin; cleared while the pin is not driven
	always_comb begin
		nxt_st.prev = clock_output_pin_out;
		nxt_st.run = (clock_output_pin_out != st_ff.prev) ? 8'h01 : st_ff.run + 8'h01;
		// the idle low and the first high phase may both be short: arm on one edge, judge later
		nxt_st.arm = st_ff.arm | (clock_output_pin_out != st_ff.prev);
		nxt_st.seen = st_ff.seen | (st_ff.arm && clock_output_pin_out != st_ff.prev);
		if (clock_output_pin_oe_n) begin
			nxt_st.run = 8'h00;
			nxt_st.arm = 1'b0;
			nxt_st.seen = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		st_ff <= rst ? '0 : nxt_st;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// phases before the second clock pin edge are partial, so only later phases are judged
	property p_clk_phase;
		!clock_output_pin_oe_n && st_ff.seen && clock_output_pin_out != st_ff.prev
		|-> st_ff.run >= CLK_PERIOD_CYC / 2 && st_ff.run <= (CLK_PERIOD_CYC + 1) / 2;
	endproperty
	a_clk_phase: assert property (p_clk_phase) else $error("clock pin phase length wrong");
	property p_clk_run;
		!clock_output_pin_oe_n && st_ff.seen |-> st_ff.run <= (CLK_PERIOD_CYC + 1) / 2;
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("clock pin stuck");
	property p_host_clkin;
		host_mode |-> clock_output_pin_oe_n;
	endproperty
	a_host_clkin: assert property (p_host_clkin) else $error("clock pin driven in host mode");
	property p_host_od;
		host_mode |-> !transmit_data_pin_out;
	endproperty
	a_host_od: assert property (p_host_od) else $error("data line driven high");
	property p_preset_sda;
		!host_mode |-> transmit_data_pin_oe_n;
	endproperty
	a_preset_sda: assert property (p_preset_sda) else $error("data pin pulled in preset");
	property p_strap;
		$fell(rst) |=> host_mode == ($past(preset_select_low) == PIN_GND
			&& $past(preset_select_high) == PIN_GND);
	endproperty
	a_strap: assert property (p_strap) else $error("mode does not follow straps");
	property p_host_idx;
		host_mode |-> preset_index == 4'h0;
	endproperty
	a_host_idx: assert property (p_host_idx) else $error("preset index in host mode");
	property p_ask_key;
		modulation_select_bit == MOD_ASK && $past(modulation_select_bit) == MOD_ASK
		&& $past(modulation_select_bit, 2) == MOD_ASK |-> amp_keyed_on == $past(tx_data_bit);
	endproperty
	a_ask_key: assert property (p_ask_key) else $error("amplitude keying wrong");
	property p_fsk_key;
		modulation_select_bit == MOD_FSK && $past(modulation_select_bit) == MOD_FSK
		&& $past(modulation_select_bit, 2) == MOD_FSK |-> amp_keyed_on;
	endproperty
	a_fsk_key: assert property (p_fsk_key) else $error("amplifier off in FSK");
	property p_data_sample;
		!host_mode && !$past(rst) && !$past(rst, 2) |-> tx_data_bit == $past(transmit_data_pin_in);
	endproperty
	a_data_sample: assert property (p_data_sample) else $error("data bit not sampled");
	property p_host_nodata;
		host_mode |=> !tx_data_bit;
	endproperty
	a_host_nodata: assert property (p_host_nodata) else $error("data bit in host mode");
	c_ack: cover property (host_mode && !transmit_data_pin_oe_n);
	c_clk: cover property (!clock_output_pin_oe_n && $rose(clock_output_pin_out));
	c_fsk: cover property (modulation_select_bit && amp_keyed_on);
endmodule // txc_props

bind txc_top txc_props #(.CLK_PERIOD_CYC(CLK_PERIOD_CYC)) u_txc_props (.*);

// *** sim/txc_host_model.sv ***
`timescale 1ns/1ps
module txc_host_model (
	// clock
	input wire logic clk,
	// data line level
	input wire logic sda,
	// scl high means released; sda_pull pulls the data line low
	output logic scl,
	output logic sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// ten clocks a phase, well above the slave's sampling needs
	task automatic hp;
		repeat (10) @(negedge clk);
	endtask
	// start or repeated start: data falls while scl high
	task automatic start;
		sda_pull = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_pull = 1'b1;
		hp();
		scl = 1'b0;
		hp();
	endtask
	task automatic stop;
		sda_pull = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_pull = 1'b0;
		hp();
	endtask
	// one bit; line sampled at the end of the high phase
	task automatic xbit(input logic b, output logic r);
		sda_pull = !b;
		hp();
		scl = 1'b1;
		hp();
		r = sda;
		scl = 1'b0;
		hp();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(d[i], r);
		xbit(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
		xbit(last, r);
	endtask
endmodule // txc_host_model

// *** sim/test_tx_config_registers_and_pin_modes.sv ***
`timescale 1ns/1ps
module test_tx_config_registers_and_pin_modes;
	import txc_pkg::*;
	localparam logic [7:0] PER = 8'h08;
	localparam longint FX = 16000000;
	// named like the ports so the instance connects by name
	logic clk, rst, transmit_data_pin_in, clock_output_pin_in;
	logic [LVL_W-1:0] preset_select_low, preset_select_high;
	logic transmit_data_pin_out, transmit_data_pin_oe_n, clock_output_pin_out, clock_output_pin_oe_n;
	logic host_mode, strap_fault, modulation_select_bit, gauss_shaping, amp_keyed_on, tx_data_bit;
	logic [3:0] preset_index;
	logic [CAR_W-1:0] tx_carrier_frequency_word_word;
	logic [2:0] amplifier_level_field;
	logic m_scl, m_pull, host_sel, data_lvl;
	logic [7:0] img [0:14];
	logic [63:0] car, dev;
	int failures, n_compared;
	// pull-ups on both lines: a released line reads high
	assign transmit_data_pin_in = host_sel ? (!m_pull && transmit_data_pin_oe_n) : data_lvl;
	assign clock_output_pin_in = clock_output_pin_oe_n ? m_scl : clock_output_pin_out;
	txc_top #(.CLK_PERIOD_CYC(PER)) u_txc_top (.*);
	txc_host_model u_txc_host_model (.clk(clk), .sda(transmit_data_pin_in), .scl(m_scl),
		.sda_pull(m_pull));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// straps only count at the first edge after reset, so every change needs one
	task automatic do_reset(input logic [1:0] lo, input logic [1:0] hi, input logic d);
		@(negedge clk);
		rst = 1'b1;
		preset_select_low = lo;
		preset_select_high = hi;
		data_lvl = d;
		host_sel = (lo == PIN_GND && hi == PIN_GND);
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic xfer_addr(input logic rd);
		logic a;
		u_txc_host_model.start();
		u_txc_host_model.wbyte({DEV_ADDR, rd}, a);
		chk("address ack", a, 1'b1);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic a;
		xfer_addr(1'b0);
		u_txc_host_model.wbyte(p, a);
		u_txc_host_model.wbyte(d, a);
		chk("data ack", a, 1'b1);
		u_txc_host_model.stop();
		if (p inside {OFF_MOD_CFG, OFF_PA_CFG, OFF_CAR_A, OFF_CAR_B, OFF_CAR_C, OFF_DEV_CFG})
			img[p[3:0]] = d;
	endtask
	// reads 0x00..0x0E in one burst, unmapped places included
	task automatic rd_all;
		logic a;
		logic [7:0] b;
		xfer_addr(1'b0);
		u_txc_host_model.wbyte(8'h00, a);
		xfer_addr(1'b1);
		for (int i = 0; i < 15; i++) begin
			u_txc_host_model.rbyte(i == 14, b);
			chk("register", b, img[i]);
		end
		u_txc_host_model.stop();
	endtask
	task automatic t_straps;
		for (int h = 0; h < 3; h++) begin
			for (int l = 0; l < 3; l++) begin
				do_reset(2'(l), 2'(h), 1'b0);
				chk("host mode", host_mode, 24'(h == 0 && l == 0));
				chk("preset index", preset_index, 24'(h * 3 + l));
			end
		end
		do_reset(2'h3, 2'h3, 1'b0);
		chk("preset index", preset_index, 24'h8);
	endtask
	task automatic t_preset;
		int n;
		logic p;
		do_reset(PIN_OPEN, PIN_VDD, 1'b0);
		chk("strap fault", strap_fault, 1'b0);
		chk("clock drive", clock_output_pin_oe_n, 1'b0);
		n = 0;
		p = clock_output_pin_out;
		repeat (80) begin
			@(negedge clk);
			if (!p && clock_output_pin_out) n++;
			p = clock_output_pin_out;
		end
		chk("clock edges", 24'(n), 24'(80 / PER));
		data_lvl = 1'b1;
		repeat (3) @(negedge clk);
		chk("data bit", tx_data_bit, 1'b1);
		chk("keyed", amp_keyed_on, 1'b1);
		chk("carrier_frequency_word", tx_carrier_frequency_word_word, 24'h0);
		data_lvl = 1'b0;
		repeat (3) @(negedge clk);
		chk("keyed", amp_keyed_on, 1'b0);
		do_reset(PIN_OPEN, PIN_OPEN, 1'b1);
		chk("strap fault", strap_fault, 1'b1);
	endtask
	task automatic t_host;
		logic a;
		do_reset(PIN_GND, PIN_GND, 1'b0);
		chk("clock input", clock_output_pin_oe_n, 1'b1);
		chk("power level", amplifier_level_field, 3'h0);
		foreach (img[i]) img[i] = 8'h00;
		rd_all();
		u_txc_host_model.start();
		u_txc_host_model.wbyte({DEV_ADDR ^ 7'h01, 1'b0}, a);
		chk("foreign address", a, 1'b0);
		u_txc_host_model.stop();
		car = (64'd65536 * 64'd433920000 + FX / 2) / FX;
		dev = (64'd40000 * 64'd8192) / FX;
		wr(OFF_CAR_A, car[23:16]);
		wr(OFF_CAR_B, car[15:8]);
		wr(OFF_CAR_C, car[7:0]);
		wr(OFF_DEV_CFG, {1'b1, dev[6:0]});
		wr(OFF_MOD_CFG, 8'h01);
		wr(OFF_PA_CFG, 8'h07);
		wr(8'h03, 8'hFF);
		repeat (4) @(negedge clk);
		chk("modulation", modulation_select_bit, MOD_FSK);
		chk("space carrier_frequency_word", tx_carrier_frequency_word_word, car[23:0]);
		chk("power level", amplifier_level_field, 3'h7);
		chk("gauss", gauss_shaping, 1'b1);
		chk("keyed", amp_keyed_on, 1'b1);
		rd_all();
	endtask
	// watchdog, more than twice the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		preset_select_low = PIN_OPEN;
		preset_select_high = PIN_OPEN;
		data_lvl = 1'b0;
		host_sel = 1'b0;
		failures = 0;
		n_compared = 0;
		t_straps();
		t_preset();
		t_host();
		summarize();
	end
endmodule // test_tx_config_registers_and_pin_modes
